// ===== mcjd_regs.vh
// Purpose: Constants for the conditional jump decoder
// Assumes: Register indices are word indices, byte address = 4 * index
// Notes: Opcode fields are for 16-bit instruction words
`ifndef MCJD_REGS_VH
`define MCJD_REGS_VH

// Register indices
`define MCJD_IDX_C0_STAT_A 10'h101
`define MCJD_IDX_C1_STAT_A 10'h102
`define MCJD_IDX_C0_STAT_B 10'h121
`define MCJD_IDX_C1_STAT_B 10'h122
`define MCJD_IDX_JUMP_REG0 10'h130
`define MCJD_IDX_JUMP_REG1 10'h131
`define MCJD_IDX_DEC_STAT 10'h140
`define MCJD_IDX_DEC_COUNT 10'h141

// Reset values
`define MCJD_RST_STAT 16'h0000
`define MCJD_RST_JUMP 16'h0000

// Start condition jump: prefix in bits 15:11
`define MCJD_START_PFX 5'h01
`define MCJD_START_PFX_HI 15
`define MCJD_START_PFX_LO 11
`define MCJD_START_SEL_HI 10
`define MCJD_START_SEL_LO 5

// Status bit jumps: prefix in bits 15:10
`define MCJD_FAR_PFX 6'h0f
`define MCJD_REL_PFX 6'h0c
`define MCJD_SR_PFX_HI 15
`define MCJD_SR_PFX_LO 10
`define MCJD_POL_BIT 9
`define MCJD_SR_IDX_HI 8
`define MCJD_SR_IDX_LO 5
`define MCJD_JREG_BIT 4
`define MCJD_FAR_TAIL 4'h5
`define MCJD_FAR_TAIL_HI 3
`define MCJD_FAR_TAIL_LO 0

// Signed offset field
`define MCJD_OFS_HI 4
`define MCJD_OFS_LO 0

// Decode status fields
`define MCJD_DS_TAKEN 0
`define MCJD_DS_START 1
`define MCJD_DS_FAR 2
`define MCJD_DS_REL 3

`endif

// ===== mcjd_rel_target.v
// Purpose: Relative jump target from instruction location and offset
// Assumes: Offset is a 5-bit two's complement value
// Notes: Result wraps modulo the code space
`timescale 1ns/1ps

module mcjd_rel_target #(
    parameter PC_W = 10
) (
    input wire [PC_W-1:0] base_addr,
    input wire [4:0] offset,
    output wire [PC_W-1:0] target
);
    wire [PC_W-1:0] offset_ext;

    // Sign bit spread over the upper bits gives -16 to 15
    assign offset_ext = {{(PC_W-5){offset[4]}}, offset};
    assign target = base_addr + offset_ext;
endmodule

// ===== mcjd_cond_jump.v
// Purpose: Decode and execute three conditional jump instructions
// Assumes: Instruction, its location and latched starts share clk
// Notes: APB slave holds status, jump and decode status registers
`timescale 1ns/1ps
`include "mcjd_regs.vh"

// Functional notes
// - Start pattern met: jump to relative target
// - Target is location plus signed 5-bit offset
// - Pattern bit k means start k+1 latched
// - Start jump: 00001, pattern, offset fields
// - Status match: far jump through jump register
// - Far target may be any code location
// - 4-bit index picks one of 16 status bits
// - Status word is this core's control register
// - Polarity 0 tests bit low, 1 high
// - Far jump: 001111, pol, index, reg, 0101
// - Status match: jump to relative target
// - Relative status jump: 001100, pol, index, offset
module mcjd_cond_jump #(
    parameter PC_W = 10
) (
    input wire clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire core_id,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire [PC_W-1:0] instr_addr,
    input wire [5:0] start_latched,
    output reg pc_load,
    output reg [PC_W-1:0] program_counter,
    output reg jump_taken
);
    reg [15:0] core0_control_status_a;
    reg [15:0] core1_control_status_a;
    reg [15:0] core0_control_status_b;
    reg [15:0] core1_control_status_b;
    reg [PC_W-1:0] jump_register_set [0:1];
    reg [3:0] dec_status;
    reg [15:0] dec_count;

    // Reset word is wider than the code space; only low bits are kept
    localparam [15:0] JUMP_RST = `MCJD_RST_JUMP;

    reg [31:0] next_prdata;
    reg next_pslverr;
    reg next_pc_load;
    reg [PC_W-1:0] next_program_counter;
    reg next_jump_taken;
    reg [3:0] next_dec_status;

    wire [9:0] word_index;
    wire apb_write;
    wire apb_done;
    wire [15:0] status_word;
    wire [5:0] start_pattern_select;
    wire [3:0] status_bit_index;
    wire jump_register_operand;
    wire polarity;
    wire selected_bit;
    wire is_start_jump;
    wire is_far_jump;
    wire is_rel_jump;
    wire start_met;
    wire status_met;
    wire [PC_W-1:0] rel_target;
    wire [PC_W-1:0] seq_addr;
    wire [PC_W-1:0] far_target;

    // Low two address bits are the byte lane within a word
    assign word_index = paddr[11:2];
    assign apb_done = psel & penable & pready;
    assign apb_write = apb_done & pwrite;

    // Operand fields
    assign start_pattern_select =
        instr_word[`MCJD_START_SEL_HI:`MCJD_START_SEL_LO];
    assign status_bit_index =
        instr_word[`MCJD_SR_IDX_HI:`MCJD_SR_IDX_LO];
    assign polarity = instr_word[`MCJD_POL_BIT];
    assign jump_register_operand = instr_word[`MCJD_JREG_BIT];

    // Opcode match
    assign is_start_jump =
        instr_word[`MCJD_START_PFX_HI:`MCJD_START_PFX_LO]
        == `MCJD_START_PFX;
    assign is_far_jump =
        (instr_word[`MCJD_SR_PFX_HI:`MCJD_SR_PFX_LO] == `MCJD_FAR_PFX) &&
        (instr_word[`MCJD_FAR_TAIL_HI:`MCJD_FAR_TAIL_LO]
        == `MCJD_FAR_TAIL);
    assign is_rel_jump =
        instr_word[`MCJD_SR_PFX_HI:`MCJD_SR_PFX_LO]
        == `MCJD_REL_PFX;

    // Each core tests its own control register; the b copies are plain
    // storage that no jump reads
    assign status_word = core_id ? core1_control_status_a
                                 : core0_control_status_a;
    assign selected_bit = status_word[status_bit_index];
    assign status_met = (selected_bit == polarity);

    // Bit k of the pattern stands for start k+1; exact match needed
    assign start_met = (start_latched == start_pattern_select);

    // One adder serves both relative jumps
    mcjd_rel_target #(
        .PC_W(PC_W)
    ) u_rel_target (
        .base_addr(instr_addr),
        .offset(instr_word[`MCJD_OFS_HI:`MCJD_OFS_LO]),
        .target(rel_target)
    );

    assign seq_addr = instr_addr + {{(PC_W-1){1'b0}}, 1'b1};

    // Kept out of the always block so an array write wakes the mux
    // Absolute target, no range limit
    assign far_target = jump_register_set[jump_register_operand];

    // Jump decision
    always @*
    begin
        next_pc_load = 1'b0;
        next_program_counter = program_counter;
        next_jump_taken = 1'b0;
        next_dec_status = dec_status;
        // Prefixes are disjoint, so the order of tests sets no priority
        if (instr_valid)
        begin
            if (is_start_jump)
            begin
                next_pc_load = 1'b1;
                next_jump_taken = start_met;
                next_program_counter = start_met ? rel_target
                                                 : seq_addr;
                next_dec_status = 4'h0;
                next_dec_status[`MCJD_DS_START] = 1'b1;
                next_dec_status[`MCJD_DS_TAKEN] = start_met;
            end
            else if (is_far_jump)
            begin
                next_pc_load = 1'b1;
                next_jump_taken = status_met;
                next_program_counter = status_met ? far_target
                                                  : seq_addr;
                next_dec_status = 4'h0;
                next_dec_status[`MCJD_DS_FAR] = 1'b1;
                next_dec_status[`MCJD_DS_TAKEN] = status_met;
            end
            else if (is_rel_jump)
            begin
                next_pc_load = 1'b1;
                next_jump_taken = status_met;
                next_program_counter = status_met ? rel_target
                                                  : seq_addr;
                next_dec_status = 4'h0;
                next_dec_status[`MCJD_DS_REL] = 1'b1;
                next_dec_status[`MCJD_DS_TAKEN] = status_met;
            end
            else
            begin
                next_pc_load = 1'b0;
            end
        end
    end

    // Untaken jumps fall through to the next word
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pc_load <= 1'b0;
            program_counter <= {PC_W{1'b0}};
            jump_taken <= 1'b0;
            dec_status <= 4'h0;
        end
        else
        begin
            pc_load <= next_pc_load;
            program_counter <= next_program_counter;
            jump_taken <= next_jump_taken;
            dec_status <= next_dec_status;
        end
    end

    // Counter of taken jumps; software write clears, a take in the
    // same cycle still counts so no event is lost
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dec_count <= 16'h0000;
        end
        else if (apb_write && word_index == `MCJD_IDX_DEC_COUNT)
        begin
            dec_count <= {15'h0000, next_jump_taken & next_pc_load};
        end
        else if (next_jump_taken && next_pc_load)
        begin
            dec_count <= dec_count + 16'h0001;
        end
    end

    // Register writes take effect at the completing edge only
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            core0_control_status_a <= `MCJD_RST_STAT;
            core1_control_status_a <= `MCJD_RST_STAT;
            core0_control_status_b <= `MCJD_RST_STAT;
            core1_control_status_b <= `MCJD_RST_STAT;
        end
        else if (apb_write)
        begin
            case (word_index)
                `MCJD_IDX_C0_STAT_A: core0_control_status_a <= pwdata[15:0];
                `MCJD_IDX_C1_STAT_A: core1_control_status_a <= pwdata[15:0];
                `MCJD_IDX_C0_STAT_B: core0_control_status_b <= pwdata[15:0];
                `MCJD_IDX_C1_STAT_B: core1_control_status_b <= pwdata[15:0];
                default: core0_control_status_a <= core0_control_status_a;
            endcase
        end
    end

    // Jump registers keep only the code-space bits of a written word
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            jump_register_set[0] <= JUMP_RST[PC_W-1:0];
            jump_register_set[1] <= JUMP_RST[PC_W-1:0];
        end
        else if (apb_write)
        begin
            if (word_index == `MCJD_IDX_JUMP_REG0)
            begin
                jump_register_set[0] <= pwdata[PC_W-1:0];
            end
            if (word_index == `MCJD_IDX_JUMP_REG1)
            begin
                jump_register_set[1] <= pwdata[PC_W-1:0];
            end
        end
    end

    // Read mux and error for unmapped words
    always @*
    begin
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        case (word_index)
            `MCJD_IDX_C0_STAT_A: next_prdata[15:0] = core0_control_status_a;
            `MCJD_IDX_C1_STAT_A: next_prdata[15:0] = core1_control_status_a;
            `MCJD_IDX_C0_STAT_B: next_prdata[15:0] = core0_control_status_b;
            `MCJD_IDX_C1_STAT_B: next_prdata[15:0] = core1_control_status_b;
            `MCJD_IDX_JUMP_REG0: next_prdata[PC_W-1:0] = jump_register_set[0];
            `MCJD_IDX_JUMP_REG1: next_prdata[PC_W-1:0] = jump_register_set[1];
            `MCJD_IDX_DEC_STAT: next_prdata[3:0] = dec_status;
            `MCJD_IDX_DEC_COUNT: next_prdata[15:0] = dec_count;
            default: next_pslverr = 1'b1;
        endcase
        // Decode status is read-only
        if (pwrite && word_index == `MCJD_IDX_DEC_STAT)
        begin
            next_pslverr = 1'b1;
        end
    end

    // One wait state keeps every bus output on a flip-flop
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            if (psel && penable && !pready)
            begin
                pslverr <= next_pslverr;
                prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            end
            else
            begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

// ===== mcjd_cond_jump_monitor.sv
// Purpose: Port assertions for the jump decoder
// Assumes: One clock, async active-low reset
// Notes: Status bits are unseen here, so far targets go unchecked
`timescale 1ns/1ps
module mcjd_cond_jump_monitor #(
    parameter PC_W = 10
) (
    input wire clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire instr_valid,
    input wire [15:0] instr_word,
    input wire [PC_W-1:0] instr_addr,
    input wire [5:0] start_latched,
    input wire pc_load,
    input wire [PC_W-1:0] program_counter,
    input wire jump_taken
);
    wire st = instr_word[15:11] == 5'h01;
    wire far = instr_word[15:10] == 6'h0f && instr_word[3:0] == 4'h5;
    wire rel = instr_word[15:10] == 6'h0c;
    wire jmp = instr_valid && (st || far || rel);
    wire hit = start_latched == instr_word[10:5];
    wire [PC_W-1:0] nxt = instr_addr + 1'b1;
    wire [PC_W-1:0] tgt = instr_addr +
        {{(PC_W-5){instr_word[4]}}, instr_word[4:0]};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_load; jmp |=> pc_load; endproperty
    a_load: assert property (p_load) else $error("no load");
    property p_idle; !jmp |=> !pc_load; endproperty
    a_idle: assert property (p_idle) else $error("stray load");
    property p_start; instr_valid && st |=> jump_taken == $past(hit);
    endproperty
    a_start: assert property (p_start) else $error("start");
    property p_starg;
        instr_valid && st && hit |=> program_counter == $past(tgt);
    endproperty
    a_starg: assert property (p_starg) else $error("start pc");
    property p_rel;
        instr_valid && rel |=> !jump_taken || program_counter == $past(tgt);
    endproperty
    a_rel: assert property (p_rel) else $error("rel pc");
    property p_seq;
        pc_load && !jump_taken |-> program_counter == $past(nxt);
    endproperty
    a_seq: assert property (p_seq) else $error("seq pc");
    property p_tk; jump_taken |-> pc_load; endproperty
    a_tk: assert property (p_tk) else $error("taken");
    property p_rdy; psel && $rose(penable) |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_err; pslverr |-> pready ##1 !pready; endproperty
    a_err: assert property (p_err) else $error("pslverr");
endmodule

// ===== mcjd_fetch_model.sv
// Purpose: Fetch side feeding the decoder
// Assumes: One fetch per cycle that go is high
// Notes: Idle word toggles so stale opcodes never look valid
`timescale 1ns/1ps
module mcjd_fetch_model #(
    parameter PC_W = 10
) (
    input wire clk,
    input wire rst_b,
    input wire go,
    input wire use_addr,
    input wire [15:0] word_in,
    input wire [PC_W-1:0] addr_in,
    input wire pc_load,
    input wire [PC_W-1:0] program_counter,
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic [PC_W-1:0] instr_addr
);
    logic [PC_W-1:0] fetch_pc;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            instr_valid <= 1'b0;
            instr_word <= 16'h0000;
            instr_addr <= '0;
            fetch_pc <= '0;
        end
        else
        begin
            if (pc_load)
                fetch_pc <= program_counter;
            instr_valid <= go;
            instr_word <= go ? word_in : ~instr_word;
            if (go)
                instr_addr <= use_addr ? addr_in : fetch_pc;
        end
    end
endmodule

// ===== microcore_cond_jump_decode_tb.sv
// Purpose: Self-checking bench for the jump decoder
// Assumes: Inputs change by non-blocking writes after clk rises
// Notes: PC_W of 10 keeps wrap cases short
`timescale 1ns/1ps
module microcore_cond_jump_decode_tb;
    localparam PC_W = 10;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic core_id = 0, go = 0, use_a = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, instr_valid, pc_load, jump_taken;
    logic [15:0] instr_word, word = 0;
    logic [PC_W-1:0] instr_addr, program_counter, addr = 0;
    logic [5:0] st = 0;
    integer error_cnt = 0, total_checks = 0, i;
    // Word, address, starts, expected pc, taken, load
    logic [43:0] rows [11] = '{
        {16'h0810, 10'h010, 6'h00, 10'h000, 2'b11},
        {16'h0c0f, 10'h3fa, 6'h20, 10'h009, 2'b11},
        {16'h0c0f, 10'h3fa, 6'h21, 10'h3fb, 2'b01},
        {16'h0822, 10'h100, 6'h01, 10'h102, 2'b11},
        {16'h3fe5, 10'h020, 6'h00, 10'h3ff, 2'b11},
        {16'h3e35, 10'h020, 6'h00, 10'h021, 2'b01},
        {16'h3c35, 10'h020, 6'h00, 10'h005, 2'b11},
        {16'h321f, 10'h000, 6'h00, 10'h3ff, 2'b11},
        {16'h31e5, 10'h000, 6'h00, 10'h001, 2'b01},
        {16'h3fe4, 10'h000, 6'h00, 10'h000, 2'b00},
        {16'h0000, 10'h000, 6'h00, 10'h000, 2'b00}};
    mcjd_cond_jump #(.PC_W(PC_W)) mcjd_cond_jump_i (.clk(clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_id(core_id), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_addr(instr_addr),
        .start_latched(st), .pc_load(pc_load),
        .program_counter(program_counter), .jump_taken(jump_taken));
    mcjd_fetch_model #(.PC_W(PC_W)) mcjd_fetch_model_i (.clk(clk),
        .rst_b(rst_b), .go(go), .use_addr(use_a), .word_in(word),
        .addr_in(addr), .pc_load(pc_load),
        .program_counter(program_counter), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_addr(instr_addr));
    initial
        forever #4 clk = ~clk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", n, e, g);
            error_cnt++;
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Idle edge first, so psel is never written twice in one step
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task run(input logic [15:0] w, input logic [9:0] a, input logic [5:0] s);
        word <= w;
        addr <= a;
        st <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, 12'h404, 0);
        chk("stat rst", 0, rd);
        apb(1, 12'h404, 32'hffff8001);
        apb(0, 12'h404, 0);
        chk("stat", 32'h8001, rd);
        apb(1, 12'h4c0, 32'h3ff);
        apb(1, 12'h4c4, 32'h5);
        apb(0, 12'h3fc, 0);
        chk("unmapped", 1, er);
        apb(1, 12'h500, 1);
        chk("ro write", 1, er);
        $display("registers done");
        for (i = 0; i < 11; i++)
        begin
            run(rows[i][43:28], rows[i][27:18], rows[i][17:12]);
            chk("load", rows[i][0], pc_load);
            if (rows[i][0])
            begin
                chk("pc", rows[i][11:2], program_counter);
                chk("taken", rows[i][1], jump_taken);
            end
        end
        $display("table done");
        apb(1, 12'h408, 32'h2);
        core_id <= 1'b1;
        run(16'h3e35, 10'h020, 0);
        chk("core1", 10'h005, program_counter);
        core_id <= 1'b0;
        go <= 1'b1;
        word <= 16'h0810;
        addr <= 10'h010;
        @(posedge clk);
        word <= 16'h0803;
        addr <= 10'h200;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        chk("b2b a", 10'h000, program_counter);
        @(posedge clk);
        chk("b2b b", 10'h203, program_counter);
        run(16'h3fe5, 10'h020, 0);
        use_a <= 1'b0;
        run(16'h31e5, 0, 0);
        chk("chain", 10'h000, program_counter);
        use_a <= 1'b1;
        apb(0, 12'h504, 0);
        chk("count", 10, rd);
        apb(1, 12'h504, 0);
        apb(0, 12'h504, 0);
        chk("clear", 0, rd);
        $display("special cases done");
        run(16'h0822, 10'h100, 1);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pc rst", 0, program_counter);
        rst_b <= 1'b1;
        apb(0, 12'h404, 0);
        chk("stat rst2", 0, rd);
        $display("reset done");
        end_of_test();
    end
    // Whole run is just over a hundred cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
bind mcjd_cond_jump mcjd_cond_jump_monitor #(.PC_W(PC_W)) mon_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_addr(instr_addr),
    .start_latched(start_latched), .pc_load(pc_load),
    .program_counter(program_counter), .jump_taken(jump_taken));
